// ### logic/mcs_pkg.sv
// Purpose: constants and types shared by the main clock and standby control
// Assumes: one system clock, synchronous active-high reset
// Notes: instruction strobes are one-cycle pulses from the instruction decoder
package mcs_pkg;
  // main oscillator type as recorded by the selection instructions
  typedef enum logic [1:0] {
    MCS_OSC_NONE,
    MCS_OSC_CERAMIC,
    MCS_OSC_RC,
    MCS_OSC_CRYSTAL
  } mcs_osc_e;

  // system clock source select
  localparam logic MCS_SRC_ONCHIP = 1'h0;
  localparam logic MCS_SRC_MAIN = 1'h1;

  // reset values
  localparam logic MCS_STOP_BIT_RST = 1'h1;
  localparam logic MCS_ONCHIP_RUN_RST = 1'h1;
  localparam logic MCS_PIN_FORCE_RST = 1'h1;

  // oscillation detect: two or more edges seen within the window count as running
  localparam int MCS_DET_WIN = 16;
  localparam int MCS_DET_W = 5;
  localparam logic [MCS_DET_W-1:0] MCS_DET_LAST =
    MCS_DET_W'(MCS_DET_WIN - 1);
  localparam logic [MCS_DET_W-1:0] MCS_DET_ZERO = '0;
  localparam logic [MCS_DET_W-1:0] MCS_DET_ONE = MCS_DET_W'(1);
  localparam logic [1:0] MCS_EDGE_MIN = 2'h2;
  localparam logic [1:0] MCS_EDGE_ZERO = 2'h0;
  localparam logic [1:0] MCS_EDGE_ONE = 2'h1;
endpackage

// ### logic/mcs_osc_detect.sv
// Purpose: decides whether a clock source is oscillating
// Assumes: sample input is asynchronous to sys_clk_i
// Notes: running means at least two edges in each detect window
`timescale 1ns/1ps
module mcs_osc_detect (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic osc_sample_i,
  output logic running_o
);
  import mcs_pkg::*;

  logic sync1_reg, sync2_reg, last_reg, running_reg;
  logic sync1_next, sync2_next, last_next, running_next;
  logic [MCS_DET_W-1:0] win_reg, win_next;
  logic [1:0] edges_reg, edges_next;

  // ----------------------------------------------------------------
  // edge counting over a fixed window
  // ----------------------------------------------------------------
  always_comb begin
    sync1_next = osc_sample_i;
    sync2_next = sync1_reg;
    last_next = sync2_reg;
    win_next = win_reg + MCS_DET_ONE;
    edges_next = edges_reg;
    running_next = running_reg;
    if (sync2_reg != last_reg && edges_reg != MCS_EDGE_MIN) begin
      edges_next = edges_reg + MCS_EDGE_ONE;
    end
    if (win_reg == MCS_DET_LAST) begin
      win_next = MCS_DET_ZERO;
      edges_next = MCS_EDGE_ZERO;
      running_next = (edges_reg == MCS_EDGE_MIN);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
      last_reg <= 1'h0;
      win_reg <= MCS_DET_ZERO;
      edges_reg <= MCS_EDGE_ZERO;
      running_reg <= 1'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      last_reg <= last_next;
      win_reg <= win_next;
      edges_reg <= edges_next;
      running_reg <= running_next;
    end
  end

  assign running_o = running_reg;
endmodule

// ### logic/mcs_clock_ctrl.sv
// Purpose: main oscillator type selection, clock source guard, standby entry
// Assumes: instruction strobes are one-cycle pulses, one per executed instr
// Notes: instr_exec_i marks every executed instruction, including these
// Notes: wakeup_i comes from pins and passes two flip-flops before use
`timescale 1ns/1ps
// Summary of operation
// - standby entered only by powerdown directly after arm-powerdown
// - powerdown alone, without arm just before, does nothing
// - first of three oscillator selections wins, later ones ignored
// - selection only records type; no start unless stop already cleared, no source switch
// - with no selection, main clock unusable; run on on-chip clock
// - a non-oscillating source is refused as system clock
// - stopping the source that drives the system clock is refused
// - in standby with main clock stopped, input pin forced high
// - from reset, input pin held high until selection and stop cleared
module mcs_clock_ctrl (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic instr_exec_i,
  input wire logic arm_powerdown_instr_i,
  input wire logic powerdown_instr_i,
  input wire logic select_ceramic_main_clock_instr_i,
  input wire logic select_rc_main_clock_instr_i,
  input wire logic select_crystal_main_clock_instr_i,
  input wire logic main_clock_stop_wr_i,
  input wire logic main_clock_stop_bit_i,
  input wire logic onchip_stop_wr_i,
  input wire logic onchip_stop_bit_i,
  input wire logic sys_src_wr_i,
  input wire logic sys_src_sel_i,
  input wire logic wakeup_i,
  input wire logic main_osc_sample_i,
  input wire logic onchip_osc_sample_i,
  output logic [1:0] osc_type_o,
  output logic main_osc_enable_o,
  output logic onchip_osc_enable_o,
  output logic main_clock_stop_bit_o,
  output logic sys_src_o,
  output logic armed_o,
  output logic backup_o,
  output logic main_osc_input_force_high_o,
  output logic src_refused_o,
  output logic stop_refused_o
);
  import mcs_pkg::*;

  mcs_osc_e osc_type_reg, osc_type_next;
  logic armed_reg, armed_next;
  logic backup_reg, backup_next;
  logic mstop_reg, mstop_next;
  logic ostop_reg, ostop_next;
  logic src_reg, src_next;
  logic force_reg, force_next;
  logic srcref_reg, srcref_next;
  logic stopref_reg, stopref_next;
  logic main_running, onchip_running;
  logic menable_reg, menable_next;
  logic oenable_reg, oenable_next;
  logic wake_sync1_reg, wake_sync1_next;
  logic wake_sync2_reg, wake_sync2_next;
  logic any_sel;

  // ----------------------------------------------------------------
  // oscillation detectors
  // ----------------------------------------------------------------
  mcs_osc_detect u_main_det (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .osc_sample_i(main_osc_sample_i),
    .running_o(main_running)
  );

  mcs_osc_detect u_onchip_det (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .osc_sample_i(onchip_osc_sample_i),
    .running_o(onchip_running)
  );

  assign any_sel = select_ceramic_main_clock_instr_i |
                   select_rc_main_clock_instr_i |
                   select_crystal_main_clock_instr_i;

  // ----------------------------------------------------------------
  // wakeup synchroniser
  // ----------------------------------------------------------------
  // the wakeup request is a pin level, so it is resampled twice
  // before the standby state may read it
  always_comb begin
    wake_sync1_next = wakeup_i;
    wake_sync2_next = wake_sync1_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wake_sync1_reg <= 1'h0;
      wake_sync2_reg <= 1'h0;
    end else begin
      wake_sync1_reg <= wake_sync1_next;
      wake_sync2_reg <= wake_sync2_next;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    osc_type_next = osc_type_reg;
    armed_next = armed_reg;
    backup_next = backup_reg;
    mstop_next = mstop_reg;
    ostop_next = ostop_reg;
    src_next = src_reg;
    srcref_next = 1'h0;
    stopref_next = 1'h0;

    // first selection only; no start unless stop already cleared, no switch
    if (osc_type_reg == MCS_OSC_NONE && any_sel) begin
      if (select_ceramic_main_clock_instr_i) begin
        osc_type_next = MCS_OSC_CERAMIC;
      end else if (select_rc_main_clock_instr_i) begin
        osc_type_next = MCS_OSC_RC;
      end else begin
        osc_type_next = MCS_OSC_CRYSTAL;
      end
    end

    // arm then powerdown back to back
    if (instr_exec_i) begin
      if (powerdown_instr_i && armed_reg) begin
        backup_next = 1'h1;
      end
      armed_next = arm_powerdown_instr_i;
    end
    if (backup_reg && wake_sync2_reg) begin
      backup_next = 1'h0;
    end

    // source switch only to a running source
    if (sys_src_wr_i) begin
      if (sys_src_sel_i == MCS_SRC_MAIN) begin
        if (osc_type_reg != MCS_OSC_NONE && main_running && !mstop_reg) begin
          src_next = MCS_SRC_MAIN;
        end else begin
          srcref_next = 1'h1;
        end
      end else if (onchip_running && !ostop_reg) begin
        src_next = MCS_SRC_ONCHIP;
      end else begin
        srcref_next = 1'h1;
      end
    end

    // stop bits; checked against the source chosen this same cycle,
    // so a switch and a stop together cannot stop the new source
    if (main_clock_stop_wr_i) begin
      if (main_clock_stop_bit_i && src_next == MCS_SRC_MAIN) begin
        stopref_next = 1'h1;
      end else begin
        mstop_next = main_clock_stop_bit_i;
      end
    end
    if (onchip_stop_wr_i) begin
      if (onchip_stop_bit_i && src_next == MCS_SRC_ONCHIP) begin
        stopref_next = 1'h1;
      end else begin
        ostop_next = onchip_stop_bit_i;
      end
    end

    // pin held high until selected and started, and whenever main clock is stopped
    force_next = (osc_type_next == MCS_OSC_NONE) | mstop_next |
                 (backup_next & mstop_next);

    // main oscillator runs only when selected and not stopped
    menable_next = (osc_type_next != MCS_OSC_NONE) & ~mstop_next;
    oenable_next = ~ostop_next;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      osc_type_reg <= MCS_OSC_NONE;
      armed_reg <= 1'h0;
      backup_reg <= 1'h0;
      mstop_reg <= MCS_STOP_BIT_RST;
      ostop_reg <= 1'h0;
      src_reg <= MCS_SRC_ONCHIP;
      force_reg <= MCS_PIN_FORCE_RST;
      srcref_reg <= 1'h0;
      stopref_reg <= 1'h0;
      menable_reg <= 1'h0;
      oenable_reg <= MCS_ONCHIP_RUN_RST;
    end else begin
      osc_type_reg <= osc_type_next;
      armed_reg <= armed_next;
      backup_reg <= backup_next;
      mstop_reg <= mstop_next;
      ostop_reg <= ostop_next;
      src_reg <= src_next;
      force_reg <= force_next;
      srcref_reg <= srcref_next;
      stopref_reg <= stopref_next;
      menable_reg <= menable_next;
      oenable_reg <= oenable_next;
    end
  end

  assign osc_type_o = osc_type_reg;
  assign main_osc_enable_o = menable_reg;
  assign onchip_osc_enable_o = oenable_reg;
  assign main_clock_stop_bit_o = mstop_reg;
  assign sys_src_o = src_reg;
  assign armed_o = armed_reg;
  assign backup_o = backup_reg;
  assign main_osc_input_force_high_o = force_reg;
  assign src_refused_o = srcref_reg;
  assign stop_refused_o = stopref_reg;
endmodule

// ### verif/mcs_ext_osc.sv
// Purpose: external clock feeding the main oscillator input
// Assumes: runs only while the block enables the main oscillator
// Notes: parks low when disabled
`timescale 1ns/1ps
module mcs_ext_osc (
  input wire logic en_i,
  output logic osc_o
);
  initial osc_o = 1'h0;
  // clock fed only once software enabled it
  always #23 osc_o = (en_i === 1'h1) ? ~osc_o : 1'h0;
endmodule

// ### verif/mcs_ctrl_properties.sv
// Purpose: port assertions of the clock and standby control
// Assumes: bound to mcs_clock_ctrl
// Notes: one clock domain
`timescale 1ns/1ps
module mcs_ctrl_properties (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic instr_exec_i,
  input wire logic arm_powerdown_instr_i,
  input wire logic powerdown_instr_i,
  input wire logic main_clock_stop_wr_i,
  input wire logic main_clock_stop_bit_i,
  input wire logic sys_src_wr_i,
  input wire logic sys_src_sel_i,
  input wire logic [1:0] osc_type_o,
  input wire logic main_osc_enable_o,
  input wire logic onchip_osc_enable_o,
  input wire logic main_clock_stop_bit_o,
  input wire logic sys_src_o,
  input wire logic armed_o,
  input wire logic backup_o,
  input wire logic main_osc_input_force_high_o,
  input wire logic src_refused_o,
  input wire logic stop_refused_o
);
  import mcs_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  wire logic ex = instr_exec_i;
  sequence s_arm_pd;
    ex && arm_powerdown_instr_i ##1 ex && powerdown_instr_i;
  endsequence
  chk_pd_enter: assert property (s_arm_pd |=> backup_o)
    else $error("standby not entered");
  chk_pd_alone: assert property (ex && powerdown_instr_i && !armed_o
    && !backup_o |=> !backup_o) else $error("standby without arm");
  chk_sel_once: assert property (osc_type_o != MCS_OSC_NONE
    |=> $stable(osc_type_o)) else $error("oscillator type changed");
  chk_no_sel: assert property (osc_type_o == MCS_OSC_NONE |->
    sys_src_o == MCS_SRC_ONCHIP && !main_osc_enable_o)
    else $error("main clock usable without selection");
  chk_src_guard: assert property (sys_src_wr_i && sys_src_sel_i
    && main_clock_stop_bit_o |=> src_refused_o && sys_src_o == MCS_SRC_ONCHIP
    && $past(sys_src_o) == MCS_SRC_ONCHIP) else $error("stopped source taken");
  chk_stop_guard: assert property (main_clock_stop_wr_i
    && main_clock_stop_bit_i && sys_src_o == MCS_SRC_MAIN && !sys_src_wr_i
    |=> stop_refused_o && !main_clock_stop_bit_o) else $error("source stopped");
  chk_pin_bk: assert property (backup_o && main_clock_stop_bit_o
    |-> main_osc_input_force_high_o) else $error("pin not forced");
  chk_pin_rst: assert property (osc_type_o == MCS_OSC_NONE
    |-> main_osc_input_force_high_o) else $error("pin released early");
  chk_arm_clear: assert property (armed_o && ex
    && !arm_powerdown_instr_i |=> !armed_o) else $error("arm not cleared");
  chk_sel_no_start: assert property (main_clock_stop_bit_o
    |-> !main_osc_enable_o) else $error("main oscillator runs while stopped");
  chk_src_running: assert property ((sys_src_o ? main_osc_enable_o
    : onchip_osc_enable_o)) else $error("system clock source stopped");
endmodule
bind mcs_clock_ctrl mcs_ctrl_properties i_chk (.*);

// ### verif/tb_top.sv
// Purpose: self-checking bench of the clock and standby control
// Assumes: 10 MHz clock, reset held 4 cycles
// Notes: driver queues expected states, monitor compares
`timescale 1ns/1ps
module tb_top;
  import mcs_pkg::*;
  localparam logic [12:0] EX = 13'h1000, AR = 13'h0800, PD = 13'h0400;
  localparam logic [12:0] SC = 13'h0200, MW = 13'h0040, MB = 13'h0020;
  localparam logic [12:0] OW = 13'h0010, OB = 13'h0008, SW = 13'h0004;
  localparam logic [12:0] SS = 13'h0002, WK = 13'h0001;
  logic sys_clk_i = 1'h0, srst_i = 1'h1, onchip_osc_sample_i = 1'h0;
  logic go = 1'h0, esrc, est, ebk, earm, efr;
  logic [1:0] et;
  logic [12:0] iv = '0;
  logic [6:0] prv;
  logic [8:0] n;
  logic [8:0] q[$];
  int error_cnt = 0, samples_checked = 0, cyc = 0, k, seed;
  wire logic instr_exec_i, arm_powerdown_instr_i, powerdown_instr_i;
  wire logic select_ceramic_main_clock_instr_i, select_rc_main_clock_instr_i;
  wire logic select_crystal_main_clock_instr_i, main_clock_stop_wr_i;
  wire logic main_clock_stop_bit_i, onchip_stop_wr_i, onchip_stop_bit_i;
  wire logic sys_src_wr_i, sys_src_sel_i, wakeup_i, main_osc_sample_i;
  wire logic [1:0] osc_type_o;
  wire logic main_osc_enable_o, onchip_osc_enable_o, main_clock_stop_bit_o;
  wire logic sys_src_o, armed_o, backup_o, main_osc_input_force_high_o;
  wire logic src_refused_o, stop_refused_o;
  wire logic [6:0] cur = {osc_type_o, sys_src_o, main_clock_stop_bit_o,
    backup_o, armed_o, main_osc_input_force_high_o};
  assign {instr_exec_i, arm_powerdown_instr_i, powerdown_instr_i,
    select_ceramic_main_clock_instr_i, select_rc_main_clock_instr_i,
    select_crystal_main_clock_instr_i, main_clock_stop_wr_i,
    main_clock_stop_bit_i, onchip_stop_wr_i, onchip_stop_bit_i,
    sys_src_wr_i, sys_src_sel_i, wakeup_i} = iv;
  mcs_clock_ctrl i_dut (.*);
  mcs_ext_osc i_osc (.en_i(main_osc_enable_o), .osc_o(main_osc_sample_i));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  always #37 onchip_osc_sample_i = (onchip_osc_enable_o === 1'h1) &
    ~onchip_osc_sample_i;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic miss(input string m);
    $display("mismatch at %0t: %s", $time, m);
    error_cnt++;
  endtask
  task automatic drv(input logic [12:0] v);
    @(posedge sys_clk_i);
    #10 iv = v;
  endtask
  task automatic note(input logic sr, input logic st);
    q.push_back({et, esrc, est, ebk, earm, efr, sr, st});
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miss("timeout");
      test_done;
    end
    #1;
    if (go && (cur !== prv || src_refused_o || stop_refused_o)) begin
      samples_checked++;
      if (q.size() == 0) begin
        miss("unexpected output change");
      end else begin
        n = q.pop_front();
        if (n !== {cur, src_refused_o, stop_refused_o}) miss("state differs");
      end
    end
    prv = cur;
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    seed = $urandom(26);
    {et, esrc, est, ebk, earm, efr} = 7'h09;
    repeat (4) @(posedge sys_clk_i);
    #10 srst_i = 1'h0;
    go = 1'h1;
    drv(EX | PD);
    drv(SW | SS); note(1'h1, 1'h0);
    drv(OW | OB); note(1'h0, 1'h1);
    drv('0); $display("test refusals done");
    drv(EX | SC); et = 2'h1; note(1'h0, 1'h0);
    drv(SC | (SC >> 1) | (SC >> 2));
    drv(MW); est = 1'h0; efr = 1'h0; note(1'h0, 1'h0);
    repeat (40 + $urandom % 4) drv('0);
    drv(SW | SS); esrc = 1'h1; note(1'h0, 1'h0);
    drv(MW | MB); note(1'h0, 1'h1);
    drv(SW); esrc = 1'h0; note(1'h0, 1'h0);
    drv(MW | MB); est = 1'h1; efr = 1'h1; note(1'h0, 1'h0);
    drv(SW | SS); note(1'h1, 1'h0);
    drv('0); $display("test clock source done");
    drv(EX | AR); earm = 1'h1; note(1'h0, 1'h0);
    drv(EX); earm = 1'h0; note(1'h0, 1'h0);
    drv(EX | PD);
    drv(EX);
    drv(EX | AR); earm = 1'h1; note(1'h0, 1'h0);
    drv(EX | PD); earm = 1'h0; ebk = 1'h1; note(1'h0, 1'h0);
    repeat (3) drv('0);
    drv(WK); ebk = 1'h0; note(1'h0, 1'h0);
    repeat (3) drv('0);
    $display("test standby done");
    {et, esrc, est, ebk, earm, efr} = 7'h09;
    note(1'h0, 1'h0);
    @(posedge sys_clk_i);
    #10 srst_i = 1'h1;
    repeat (2) @(posedge sys_clk_i);
    #10 srst_i = 1'h0;
    k = 1 + $urandom % 2;
    drv(EX | (SC >> k)); et = 2'(k + 1); note(1'h0, 1'h0);
    drv(SC | (SC >> 1) | (SC >> 2));
    repeat (3) drv('0);
    if (q.size() != 0) miss("expected result missing");
    $display("test reset done");
    test_done;
  end
endmodule
